// ===== shared/acr_pkg.sv
//==========================================================
// Purpose : Constants for the channel calibration register bank
// Assumes : APB slave, 32-bit data, register index times four is byte address
// Notes   : Overview list below
//==========================================================
// Overview of operation
// R01 - Channel 0 gain bits 23:8 held
// R02 - Channel 0 gain upper resets to 8000h
// R03 - Channel 0 gain low byte; reserved low byte
// R04 - Channel 1 phase is signed, resets zero
// R05 - Bit 2 set disables channel 1 filter
// R06 - Bits 1:0 select channel 1 input source
// R07 - Config resets 0000h; bits 5:3 read zero
// R08 - Channel 1 offset upper resets zero
// R09 - Channel 1 offset low byte; reserved low byte
// R10 - Channel 1 gain upper resets to 8000h
// R11 - Writes to reserved bits are ignored
package acr_pkg;
   // Register indices as printed; byte address is index times four
   localparam logic [7:0]  ACR_IDX_CH0_GAIN_UP  = 8'h0C;
   localparam logic [7:0]  ACR_IDX_CH0_GAIN_LO  = 8'h0D;
   localparam logic [7:0]  ACR_IDX_CH1_CONFIG   = 8'h0E;
   localparam logic [7:0]  ACR_IDX_CH1_OFS_UP   = 8'h0F;
   localparam logic [7:0]  ACR_IDX_CH1_OFS_LO   = 8'h10;
   localparam logic [7:0]  ACR_IDX_CH1_GAIN_UP  = 8'h11;
   // Reset values
   localparam logic [15:0] ACR_RST_GAIN_UP      = 16'h8000;
   localparam logic [15:0] ACR_RST_ZERO         = 16'h0000;
   // Writable masks; zero bits are reserved
   localparam logic [15:0] ACR_MASK_FULL        = 16'hFFFF;
   localparam logic [15:0] ACR_MASK_LO_BYTE     = 16'hFF00;
   localparam logic [15:0] ACR_MASK_CONFIG      = 16'hFFC7;
   // Config field positions
   localparam int          ACR_PHASE_MSB        = 15;
   localparam int          ACR_PHASE_LSB        = 6;
   localparam int          ACR_DCOFF_BIT        = 2;
   localparam int          ACR_SEL_MSB          = 1;
   // Input select codes
   typedef enum logic [1:0] {
      ACR_SEL_PINS  = 2'b00,
      ACR_SEL_SHORT = 2'b01,
      ACR_SEL_POS   = 2'b10,
      ACR_SEL_NEG   = 2'b11
   } acr_sel_t;
endpackage

// ===== design/acr_regs.sv
//==========================================================
// Purpose : APB register bank for channel 0 gain and channel 1 config/calibration
// Assumes : Zero-wait APB; unmapped addresses answer pslverr
// Notes   : Channel 0 gain and channel 1 offset are 24-bit outputs; channel 1 gain upper is 16-bit
//==========================================================
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module acr_regs
   import acr_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               global_dc_filter_setting,
   output logic      [23:0]        ch0_gain_cal,
   output logic signed [9:0]       ch1_phase_delay,
   output logic                    ch1_dc_filter_en,
   output acr_sel_t                ch1_input_select,
   output logic      [23:0]        ch1_offset_cal,
   output logic      [15:0]        ch1_gain_upper_field
);
   //==========================================================
   // Decode
   //==========================================================
   localparam int NREG = 6;
   // Reset values per slot; both gain words start at unity gain
   localparam logic [15:0] RST_V [NREG] = '{
      ACR_RST_GAIN_UP,   // see R02
      ACR_RST_ZERO,
      ACR_RST_ZERO,      // see R07
      ACR_RST_ZERO,      // see R08
      ACR_RST_ZERO,
      ACR_RST_GAIN_UP    // see R10
   };
   // Writable masks per slot; a zero bit is reserved and reads zero
   localparam logic [15:0] MSK_V [NREG] = '{
      ACR_MASK_FULL,     // see R01
      ACR_MASK_LO_BYTE,  // see R03
      ACR_MASK_CONFIG,   // see R07
      ACR_MASK_FULL,
      ACR_MASK_LO_BYTE,  // see R09
      ACR_MASK_FULL
   };
   logic [15:0] reg_q [NREG];
   logic [3:0]  slot;
   logic [2:0]  hit;
   logic        mapped;
   logic        wr_acc;

   // Index from word address; misaligned addresses are unmapped
   function automatic logic [3:0] acr_decode(input logic [11:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      if (a[1:0] != 2'b00 || a[11:10] != 2'b00)  acr_decode = 4'hF;
      else if (idx == ACR_IDX_CH0_GAIN_UP)        acr_decode = 4'h0;
      else if (idx == ACR_IDX_CH0_GAIN_LO)        acr_decode = 4'h1;
      else if (idx == ACR_IDX_CH1_CONFIG)         acr_decode = 4'h2;
      else if (idx == ACR_IDX_CH1_OFS_UP)         acr_decode = 4'h3;
      else if (idx == ACR_IDX_CH1_OFS_LO)         acr_decode = 4'h4;
      else if (idx == ACR_IDX_CH1_GAIN_UP)        acr_decode = 4'h5;
      else                                        acr_decode = 4'hF;
   endfunction

   // One decode feeds both the slot index and the mapped flag
   assign slot    = acr_decode(paddr);
   assign hit     = slot[2:0];
   assign mapped  = (slot != 4'hF);
   assign wr_acc  = psel && penable && pwrite && mapped;
   // Single-cycle access keeps software latency fixed
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   //==========================================================
   // Storage
   //==========================================================
   // Byte strobes apply; reserved bits never take write data
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               reg_q[g] <= RST_V[g];   // see R02
            end else if (wr_acc && hit == 3'(g)) begin
               if (pstrb[0]) reg_q[g][7:0]  <= pwdata[7:0] & MSK_V[g][7:0];   // see R11
               if (pstrb[1]) reg_q[g][15:8] <= pwdata[15:8] & MSK_V[g][15:8];
            end
         end
      end
   endgenerate

   // Read data registered on the setup cycle, valid in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite && mapped) begin
         prdata <= {16'h0000, reg_q[hit] & MSK_V[hit]};
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
      end
   end

   //==========================================================
   // Outputs to the channel logic
   //==========================================================
   assign ch0_gain_cal         = {reg_q[0], reg_q[1][15:8]};                      // see R03
   assign ch1_phase_delay      = $signed(reg_q[2][ACR_PHASE_MSB:ACR_PHASE_LSB]);  // see R04
   // Per-channel disable overrides the global filter setting
   assign ch1_dc_filter_en     = global_dc_filter_setting && !reg_q[2][ACR_DCOFF_BIT]; // see R05
   assign ch1_input_select     = acr_sel_t'(reg_q[2][ACR_SEL_MSB:0]);             // see R06
   assign ch1_offset_cal       = {reg_q[3], reg_q[4][15:8]};                      // see R09
   assign ch1_gain_upper_field = reg_q[5];                                        // see R10

   //==========================================================
   // Checks
   //==========================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cfg_reserved:  assert property (reg_q[2][5:3] == 3'b000) // see R07
      else $error("config reserved bits set");
   a_lo_reserved:   assert property (reg_q[1][7:0] == 8'h00 && reg_q[4][7:0] == 8'h00) // see R11
      else $error("low byte reserved set");
   a_ch0_write:     assert property (wr_acc && hit == 3'd0 && pstrb == 4'hF |=> reg_q[0] == $past(pwdata[15:0])) // see R01
      else $error("ch0 gain upper write lost");
   a_ch0_lo_write:  assert property (wr_acc && hit == 3'd1 && pstrb[1] |=> ch0_gain_cal[7:0] == $past(pwdata[15:8])) // see R03
      else $error("ch0 gain lower write lost");
   a_ofs_write:     assert property (wr_acc && hit == 3'd3 && pstrb[1:0] == 2'b11 |=> ch1_offset_cal[23:8] == $past(pwdata[15:0])) // see R08
      else $error("ch1 offset upper write lost");
   a_ofs_lo_write:  assert property (wr_acc && hit == 3'd4 && pstrb[1] |=> ch1_offset_cal[7:0] == $past(pwdata[15:8])) // see R09
      else $error("ch1 offset lower write lost");
   a_gain1_write:   assert property (wr_acc && hit == 3'd5 && pstrb[1:0] == 2'b11 |=> ch1_gain_upper_field == $past(pwdata[15:0])) // see R10
      else $error("ch1 gain upper write lost");
   a_dc_filter:     assert property (reg_q[2][2] |-> !ch1_dc_filter_en) // see R05
      else $error("dc filter not disabled");
   a_dc_global:     assert property (!reg_q[2][2] |-> ch1_dc_filter_en == global_dc_filter_setting) // see R05
      else $error("dc filter not following global");
   // Values right after reset release, before any access can land
   a_reset_values:  assert property ($rose(presetn) |-> reg_q[0] == 16'h8000 && reg_q[5] == 16'h8000
                                     && reg_q[2] == 16'h0000 && reg_q[3] == 16'h0000) // see R02
      else $error("reset values wrong");
   // Misaligned addresses are always refused
   a_misalign_err:  assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr) // see R11
      else $error("misaligned access not refused");
   // A refused write leaves every calibration word alone
   a_refused_keep:  assert property (psel && penable && pwrite && pslverr |=> $stable(ch0_gain_cal)
                                     && $stable(ch1_offset_cal) && $stable(ch1_gain_upper_field)) // see R11
      else $error("refused write changed state");
   a_rdata_upper:   assert property (prdata[31:16] == 16'h0000) // see R07
      else $error("read data upper half not zero");
   // A cleared byte strobe keeps its byte
   a_strobe_hold:   assert property (wr_acc && hit == 3'd0 && !pstrb[0] |=> reg_q[0][7:0] == $past(reg_q[0][7:0])) // see R01
      else $error("unstrobed byte changed");
   a_idle_hold:     assert property (!psel |=> $stable(reg_q[0]) && $stable(reg_q[5])) // see R10
      else $error("register changed without access");
   a_phase_write:   assert property (wr_acc && hit == 3'd2 && pstrb[1:0] == 2'b11 |=> ch1_phase_delay == $past(pwdata[15:6])) // see R04
      else $error("phase write lost");
   a_sel_write:     assert property (wr_acc && hit == 3'd2 && pstrb[0] |=> ch1_input_select == $past(pwdata[1:0])) // see R06
      else $error("input select write lost");
   a_read_data:     assert property (psel && !penable && !pwrite && mapped && hit == 3'd0 ##1 penable |-> prdata[31:16] == 16'h0000 && prdata[15:0] == $past(reg_q[0])) // see R02
      else $error("read data mismatch");

   c_cfg_write:  cover property (wr_acc && hit == 3'd2);
   c_read_gain:  cover property (psel && penable && !pwrite && hit == 3'd0);
   c_unmapped:   cover property (pslverr);
   c_neg_sel:    cover property (ch1_input_select == ACR_SEL_NEG);
endmodule // acr_regs

// ===== sim/tb_acr_regs.sv
// Purpose : Self-checking bench for the calibration register bank
// Assumes : Zero-wait APB slave; byte address is register index times four
// Notes   : One task per scenario; every wait is bounded
`timescale 1ns/1ps
module tb_acr_regs;
   import acr_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, glob, pready, pslverr, err, dcen;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic [23:0]       g0, o1;
   logic signed [9:0] ph;
   acr_sel_t          sel;
   logic [15:0]       g1;
   int                miscompares = 0;
   int                checks_done = 0;
   localparam logic [7:0] IDX [6] = '{ACR_IDX_CH0_GAIN_UP, ACR_IDX_CH0_GAIN_LO, ACR_IDX_CH1_CONFIG,
                                      ACR_IDX_CH1_OFS_UP, ACR_IDX_CH1_OFS_LO, ACR_IDX_CH1_GAIN_UP};
   acr_regs u_acr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_dc_filter_setting(glob), .ch0_gain_cal(g0), .ch1_phase_delay(ph), .ch1_dc_filter_en(dcen),
      .ch1_input_select(sel), .ch1_offset_cal(o1), .ch1_gain_upper_field(g1));
   //==========================================================
   // Helpers
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; a clock edge passes after release so calls may follow at once
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   //==========================================================
   // Scenarios
   task automatic t_reset;
      logic [15:0] ex [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, {2'b00, IDX[i], 2'b00}, 32'h0);
         chk("reset value", {16'h0, ex[i]}, rd);
      end
      chk("ch0 gain", 32'h800000, {8'h0, g0});
      chk("phase", 32'h0, {22'h0, ph});
   endtask
   // All ones then distinct halves; reserved bits must stay zero
   task automatic t_rw;
      logic [15:0] ms [6] = '{16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, {2'b00, IDX[i], 2'b00}, 32'hFFFFFFFF);
         apb(1'b0, {2'b00, IDX[i], 2'b00}, 32'h0);
         chk("masked readback", {16'h0, ms[i]}, rd);
      end
      chk("ch1 gain", 32'hFFFF, {16'h0, g1});
      apb(1'b1, 12'h030, 32'h1234);
      apb(1'b1, 12'h034, 32'h56AB);
      apb(1'b1, 12'h03C, 32'h9ABC);
      apb(1'b1, 12'h040, 32'hDEFF);
      apb(1'b0, 12'h034, 32'h0);
      chk("ch0 lower", 32'h5600, rd);
      chk("mapped error", 32'h0, {31'h0, err});
      chk("ch0 gain", 32'h123456, {8'h0, g0});
      chk("ch1 offset", 32'h9ABCDE, {8'h0, o1});
   endtask
   // Every select code, filter bit and global setting, with a negative phase
   task automatic t_cfg;
      logic [9:0] p;
      for (int k = 0; k < 16; k++) begin
         p = 10'h200 + 10'(k);
         glob <= k[3];
         apb(1'b1, 12'h038, {16'h0, p, 3'b111, k[2], k[1:0]});
         apb(1'b0, 12'h038, 32'h0);
         chk("config", {16'h0, p, 3'b000, k[2], k[1:0]}, rd);
         chk("select", 32'(k[1:0]), {30'h0, sel});
         chk("filter", 32'(k[3] & ~k[2]), {31'h0, dcen});
         chk("phase", {22'h0, p}, {22'h0, ph});
         chk("phase sign", 32'h1, {31'h0, ph < 0});
      end
   endtask
   // Unmapped and misaligned accesses are refused and change nothing
   task automatic t_bad;
      apb(1'b1, 12'h048, 32'h0);
      chk("error", 32'h1, {31'h0, err});
      apb(1'b1, 12'h045, 32'h0);
      chk("error", 32'h1, {31'h0, err});
      apb(1'b0, 12'h048, 32'h0);
      chk("error data", 32'h0, rd);
      apb(1'b0, 12'h044, 32'h0);
      chk("ch1 gain kept", 32'hFFFF, rd);
      pstrb <= 4'h2;
      apb(1'b1, 12'h030, 32'hAAAA);
      pstrb <= 4'hF;
      apb(1'b0, 12'h030, 32'h0);
      chk("strobed upper byte", 32'hAA34, rd);
   endtask
   //==========================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'hF;
      glob    = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_rw();
      t_cfg();
      t_bad();
      end_sim();
   end
endmodule // tb_acr_regs
